//--- ssc_env_model.sv
// model of the powered side: store voltages seen through the comparators
module ssc_env_model
#(
	parameter int STORE_LOW_MV = 2000,
	parameter int APP_HIGH_MV  = 3300,
	parameter int SPLIT_LOW_MV = 2400,
	parameter int CUTOFF_MV    = 1800
)
(
	input  wire logic        clk,
	input  wire logic [15:0] sts_mv,
	input  wire logic [15:0] lts_mv,
	output logic             above_low = 1'b0,
	output logic             above_app = 1'b0,
	output logic             below_split = 1'b0,
	output logic             lts_ok = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;

	// comparator results settle just after the edge, like a sampled detector
	always @(posedge clk)
	begin
		above_low   <= #1 sts_mv > STORE_LOW_MV;
		above_app   <= #1 sts_mv > APP_HIGH_MV;
		below_split <= #1 sts_mv < SPLIT_LOW_MV;
		lts_ok      <= #1 lts_mv > CUTOFF_MV;
	end
endmodule // ssc_env_model

//--- ssc_pkg.sv
// constants and types for the supply switch and cell control block
package ssc_pkg;

	localparam logic [7:0] ADDR_STORE_CELL   = 8'h06;
	localparam logic [7:0] ADDR_REGULATOR    = 8'h0e;
	localparam logic [7:0] ADDR_LOW_HARVEST  = 8'h0f;
	localparam logic [7:0] ADDR_AUX_SOURCE   = 8'h10;
	localparam logic [7:0] ADDR_AUX_GND_MODE = 8'h11;
	localparam logic [7:0] ADDR_PWR_ENABLE   = 8'h19;
	localparam logic [7:0] ADDR_PROTECT_KEY  = 8'h1b;
	localparam logic [7:0] ADDR_PROT_LAST    = 8'h18;
	localparam logic [7:0] KEY_UNLOCK        = 8'h4b;

	localparam logic [7:0] MASK_STORE_CELL   = 8'h07;
	localparam logic [7:0] MASK_REGULATOR    = 8'hff;
	localparam logic [7:0] MASK_LOW_HARVEST  = 8'h7f;
	localparam logic [7:0] MASK_AUX_SOURCE   = 8'h3f;
	localparam logic [7:0] MASK_AUX_GND_MODE = 8'h07;
	localparam logic [7:0] MASK_PWR_ENABLE   = 8'hfe;
	localparam logic [7:0] RESET_BYTE        = 8'h00;

	// field positions
	localparam int POS_OFF_GROUND   = 7;
	localparam int POS_AUX_LEVEL    = 4;
	localparam int POS_FORCE_MAIN   = 3;
	localparam int POS_MAIN_LEVEL   = 0;
	localparam int POS_CONV_OFF     = 7;
	localparam int POS_GND_EN       = 4;
	localparam int POS_AUX_EN       = 1;
	localparam int POS_GND_OPEN_LH  = 4;
	localparam int POS_AUX_OFF_LH   = 1;
	localparam int POS_MAIN_OFF_LH  = 0;
	localparam int POS_FORCE_JOIN   = 2;
	localparam int POS_PRIM_CELL    = 1;
	localparam int POS_GUARD_OFF    = 0;

	localparam logic [1:0] SRC_STORE    = 2'h0;
	localparam logic [1:0] SRC_REG      = 2'h1;
	localparam logic [1:0] SRC_AUTO_FLT = 2'h2;
	localparam logic [1:0] SRC_AUTO_GND = 2'h3;

	// confirmation gap between two store measurements
	localparam int CLK_PERIOD_PS    = 5000;
	localparam int T_CONFIRM_US     = 1000;
	localparam int CONFIRM_CYCLES   = (T_CONFIRM_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [1:0] JOIN_HRV_PERIODS = 2'h2;

	typedef enum logic [1:0]
	{
		OUT_FLOAT = 2'h0,
		OUT_STORE = 2'h1,
		OUT_REG   = 2'h2,
		OUT_GND   = 2'h3
	} ssc_out_type;

	typedef enum logic [1:0]
	{
		ST_SPLIT   = 2'b00,
		ST_CONFIRM = 2'b01,
		ST_JOINED  = 2'b11
	} ssc_join_type;

	// regulator level in millivolts from its 3-bit code
	function automatic logic [11:0] ssc_level_mv(input logic [2:0] code);
		logic [11:0] mv;
		mv = 12'h0;
		unique case (code)
			3'h0: mv = 12'd1200;
			3'h1: mv = 12'd1550;
			3'h2: mv = 12'd1650;
			3'h3: mv = 12'd1800;
			3'h4: mv = 12'd2000;
			3'h5: mv = 12'd2200;
			3'h6: mv = 12'd2400;
			3'h7: mv = 12'd2600;
		endcase
		return mv;
	endfunction

endpackage : ssc_pkg

//--- ssc_supply_ctrl.sv
// supply output switching and primary cell store joining logic
module ssc_supply_ctrl
	import ssc_pkg::*;
#(
	parameter int unsigned CONFIRM_CYC = CONFIRM_CYCLES
)
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        boot_done,
	input  wire logic        nvm_load_en,
	input  wire logic [7:0]  nvm_load_addr,
	input  wire logic [7:0]  nvm_load_data,
	input  wire logic        reg_wr_en,
	input  wire logic [7:0]  reg_wr_addr,
	input  wire logic [7:0]  reg_wr_data,
	input  wire logic [7:0]  reg_rd_addr,
	input  wire logic        txn_end,
	input  wire logic        sts_above_store_low_upper,
	input  wire logic        sts_above_app_high,
	input  wire logic        sts_below_split_low_upper,
	input  wire logic        lts_above_store_cutoff,
	input  wire logic        harvest_low,
	input  wire logic        sts_meas_tick,
	input  wire logic        hrv_meas_tick,
	input  wire logic [5:0]  thr_code,
	output logic      [7:0]  reg_rd_data_r,
	output ssc_out_type      main_out_r,
	output ssc_out_type      aux_out_r [3],
	output logic      [2:0]  aux_gnd_connect_r,
	output logic             main_reg_on_r,
	output logic      [11:0] main_level_mv_r,
	output logic      [11:0] aux_level_mv_r,
	output logic             step_up_converter_off_r,
	output logic             lts_charge_allowed_r,
	output logic             stores_joined_r,
	output logic             battery_guard_active_r,
	output logic             lux_allowed_r,
	output logic      [6:0]  thr_units_r
);

	logic [7:0]   store_cell_config_r;
	logic [7:0]   regulator_config_r;
	logic [7:0]   low_harvest_switch_config_r;
	logic [7:0]   aux_output_source_config_r;
	logic [7:0]   aux_ground_mode_config_r;
	logic [7:0]   power_switch_enable_r;
	logic [7:0]   protect_key_r;
	logic [4:0]   sync1_r;
	logic [4:0]   sync2_r;
	ssc_join_type join_st_r;
	logic [17:0]  confirm_cnt_r;
	logic [1:0]   hrv_cnt_r;

	logic sup_ok, app_high, split_low, lts_ok, hl;
	logic prot_on, guard, force_join, prim, auto_join;
	logic main_en;
	logic wr_ok;

	// two-stage synchroniser for comparator and flag levels
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync1_r <= 5'h0;
			sync2_r <= 5'h0;
		end
		else
		begin
			sync1_r <= {harvest_low, lts_above_store_cutoff, sts_below_split_low_upper,
				sts_above_app_high, sts_above_store_low_upper};
			sync2_r <= sync1_r;
		end
	end

	assign sup_ok    = sync2_r[0];
	assign app_high  = sync2_r[1];
	assign split_low = sync2_r[2];
	assign lts_ok    = sync2_r[3];
	assign hl        = sync2_r[4];

	// protected range opens only with the unlock key
	assign wr_ok = reg_wr_en && (reg_wr_addr > ADDR_PROT_LAST || protect_key_r == KEY_UNLOCK);

	// key register, cleared at end of transaction
	always_ff @(posedge clk)
	begin
		if (!rst_n || txn_end)
			protect_key_r <= RESET_BYTE;
		else if (reg_wr_en && reg_wr_addr == ADDR_PROTECT_KEY)
			protect_key_r <= reg_wr_data;
	end

	// configuration registers: nonvolatile load during boot, software after
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			store_cell_config_r         <= RESET_BYTE;
			regulator_config_r          <= RESET_BYTE;
			low_harvest_switch_config_r <= RESET_BYTE;
			aux_output_source_config_r  <= RESET_BYTE;
			aux_ground_mode_config_r    <= RESET_BYTE;
			power_switch_enable_r       <= RESET_BYTE;
		end
		else if (!boot_done)
		begin
			if (nvm_load_en)
			begin
				unique case (nvm_load_addr)
					ADDR_STORE_CELL:   store_cell_config_r <= nvm_load_data & MASK_STORE_CELL;
					ADDR_REGULATOR:    regulator_config_r <= nvm_load_data & MASK_REGULATOR;
					ADDR_LOW_HARVEST:  low_harvest_switch_config_r <= nvm_load_data & MASK_LOW_HARVEST;
					ADDR_AUX_SOURCE:   aux_output_source_config_r <= nvm_load_data & MASK_AUX_SOURCE;
					ADDR_AUX_GND_MODE: aux_ground_mode_config_r <= nvm_load_data & MASK_AUX_GND_MODE;
					ADDR_PWR_ENABLE:   power_switch_enable_r <= nvm_load_data & MASK_PWR_ENABLE;
					default:           ;
				endcase
			end
		end
		else if (wr_ok)
		begin
			unique case (reg_wr_addr)
				ADDR_STORE_CELL:   store_cell_config_r <= reg_wr_data & MASK_STORE_CELL;
				ADDR_REGULATOR:    regulator_config_r <= reg_wr_data & MASK_REGULATOR;
				ADDR_LOW_HARVEST:  low_harvest_switch_config_r <= reg_wr_data & MASK_LOW_HARVEST;
				ADDR_AUX_SOURCE:   aux_output_source_config_r <= reg_wr_data & MASK_AUX_SOURCE;
				ADDR_AUX_GND_MODE: aux_ground_mode_config_r <= reg_wr_data & MASK_AUX_GND_MODE;
				ADDR_PWR_ENABLE:   power_switch_enable_r <= reg_wr_data & MASK_PWR_ENABLE;
				default:           ;
			endcase
		end
	end

	// read port, unmapped addresses read zero
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			reg_rd_data_r <= RESET_BYTE;
		else
		begin
			unique case (reg_rd_addr)
				ADDR_STORE_CELL:   reg_rd_data_r <= store_cell_config_r;
				ADDR_REGULATOR:    reg_rd_data_r <= regulator_config_r;
				ADDR_LOW_HARVEST:  reg_rd_data_r <= low_harvest_switch_config_r;
				ADDR_AUX_SOURCE:   reg_rd_data_r <= aux_output_source_config_r;
				ADDR_AUX_GND_MODE: reg_rd_data_r <= aux_ground_mode_config_r;
				ADDR_PWR_ENABLE:   reg_rd_data_r <= power_switch_enable_r;
				ADDR_PROTECT_KEY:  reg_rd_data_r <= protect_key_r;
				default:           reg_rd_data_r <= RESET_BYTE;
			endcase
		end
	end

	// primary cell controls
	assign prim       = store_cell_config_r[POS_PRIM_CELL];
	assign prot_on    = !store_cell_config_r[POS_GUARD_OFF];
	assign guard      = prot_on && !lts_ok;
	assign force_join = prim && store_cell_config_r[POS_FORCE_JOIN] && !guard;
	assign auto_join  = prim && join_st_r == ST_JOINED && !(prot_on && !lts_ok);

	// automatic join sequence
	always_ff @(posedge clk)
	begin
		if (!rst_n || !prim)
		begin
			join_st_r     <= ST_SPLIT;
			confirm_cnt_r <= 18'h0;
			hrv_cnt_r     <= 2'h0;
		end
		else
		begin
			unique case (join_st_r)
				ST_SPLIT:
				begin
					hrv_cnt_r <= 2'h0;
					if (hl)
						join_st_r <= ST_JOINED;
					else if (sts_meas_tick && split_low)
					begin
						join_st_r     <= ST_CONFIRM;
						confirm_cnt_r <= 18'(CONFIRM_CYC - 1);
					end
				end
				ST_CONFIRM:
				begin
					if (hl)
						join_st_r <= ST_JOINED;
					else if (confirm_cnt_r != 18'h0)
						confirm_cnt_r <= confirm_cnt_r - 18'h1;
					else
						join_st_r <= split_low ? ST_JOINED : ST_SPLIT;
				end
				ST_JOINED:
				begin
					if (hrv_meas_tick)
					begin
						if (hrv_cnt_r == JOIN_HRV_PERIODS - 2'h1)
						begin
							hrv_cnt_r <= 2'h0;
							if (!hl)
								join_st_r <= ST_SPLIT;
						end
						else
							hrv_cnt_r <= hrv_cnt_r + 2'h1;
					end
				end
				default: join_st_r <= ST_SPLIT;
			endcase
		end
	end

	// store switch, converter and status outputs
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			stores_joined_r         <= 1'b0;
			step_up_converter_off_r <= 1'b0;
			lts_charge_allowed_r    <= 1'b0;
			battery_guard_active_r  <= 1'b0;
			lux_allowed_r           <= 1'b0;
			thr_units_r             <= 7'h0;
		end
		else
		begin
			stores_joined_r <= force_join || auto_join;
			step_up_converter_off_r <= power_switch_enable_r[POS_CONV_OFF] || force_join;
			lts_charge_allowed_r <= !prim;
			battery_guard_active_r <= guard;
			lux_allowed_r <= !prim || force_join;
			thr_units_r <= {1'b0, thr_code} + 7'h1;
		end
	end

	// main output enable: low-harvest off bit disables it
	assign main_en = sup_ok && !(hl && low_harvest_switch_config_r[POS_MAIN_OFF_LH]);

	// main output and regulator
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			main_out_r      <= OUT_FLOAT;
			main_reg_on_r   <= 1'b0;
			main_level_mv_r <= 12'h0;
			aux_level_mv_r  <= 12'h0;
		end
		else
		begin
			main_level_mv_r <= ssc_level_mv(regulator_config_r[POS_MAIN_LEVEL +: 3]);
			aux_level_mv_r  <= ssc_level_mv(regulator_config_r[POS_AUX_LEVEL +: 3]);
			if (!boot_done)
			begin
				main_out_r    <= OUT_FLOAT;
				main_reg_on_r <= 1'b0;
			end
			else if (main_en)
			begin
				main_reg_on_r <= app_high || regulator_config_r[POS_FORCE_MAIN];
				main_out_r <= (app_high || regulator_config_r[POS_FORCE_MAIN]) ? OUT_REG
					: OUT_STORE;
			end
			else
			begin
				main_reg_on_r <= 1'b0;
				main_out_r <= regulator_config_r[POS_OFF_GROUND] ? OUT_GND : OUT_FLOAT;
			end
		end
	end

	// auxiliary outputs and ground pins
	for (genvar i = 0; i < 3; i++)
	begin : g_aux
		logic [1:0] src;
		logic       on;
		logic       gnd_on;
		assign src = aux_output_source_config_r[2 * i +: 2];
		assign on = sup_ok && power_switch_enable_r[POS_AUX_EN + i]
			&& !(hl && low_harvest_switch_config_r[POS_AUX_OFF_LH + i]);
		assign gnd_on = sup_ok && power_switch_enable_r[POS_GND_EN + i]
			&& !(aux_ground_mode_config_r[i] && app_high)
			&& !(hl && low_harvest_switch_config_r[POS_GND_OPEN_LH + i]);

		always_ff @(posedge clk)
		begin
			if (!rst_n)
			begin
				aux_out_r[i]         <= OUT_FLOAT;
				aux_gnd_connect_r[i] <= 1'b0;
			end
			else if (!boot_done)
			begin
				aux_out_r[i]         <= OUT_FLOAT;
				aux_gnd_connect_r[i] <= 1'b0;
			end
			else
			begin
				aux_gnd_connect_r[i] <= gnd_on;
				if (!on)
					aux_out_r[i] <= (src == SRC_AUTO_GND) ? OUT_GND : OUT_FLOAT;
				else if (src == SRC_STORE)
					aux_out_r[i] <= OUT_STORE;
				else if (src == SRC_REG)
					aux_out_r[i] <= OUT_REG;
				else
					aux_out_r[i] <= app_high ? OUT_REG : OUT_STORE;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_boot_float: assert property (!boot_done && !$past(boot_done)
		|-> main_out_r == OUT_FLOAT && aux_gnd_connect_r == 3'h0 && aux_out_r[0] == OUT_FLOAT
		&& aux_out_r[1] == OUT_FLOAT && aux_out_r[2] == OUT_FLOAT)
		else $error("output driven during boot");
	a_main_range: assert property (boot_done && sup_ok && !app_high && !low_harvest_switch_config_r[0]
		&& !regulator_config_r[3] ##1 boot_done |-> main_out_r == OUT_STORE)
		else $error("main output not on store in range");
	a_main_force: assert property (boot_done && sup_ok && !hl && regulator_config_r[3]
		##1 boot_done |-> main_reg_on_r)
		else $error("forced main regulator not on");
	a_main_off: assert property (boot_done && !sup_ok ##1 boot_done
		|-> main_out_r == ($past(regulator_config_r[7]) ? OUT_GND : OUT_FLOAT))
		else $error("disabled main output state wrong");
	a_aux_off_gnd: assert property (boot_done && !power_switch_enable_r[1]
		&& aux_output_source_config_r[1:0] == SRC_AUTO_GND ##1 boot_done
		|-> aux_out_r[0] == OUT_GND)
		else $error("disabled aux not grounded");
	a_aux_auto_reg: assert property (boot_done && sup_ok && app_high && power_switch_enable_r[1]
		&& !hl && aux_output_source_config_r[1] ##1 boot_done |-> aux_out_r[0] == OUT_REG)
		else $error("auto aux not on regulator");
	a_guard_off: assert property (store_cell_config_r[0] |=> !battery_guard_active_r)
		else $error("guard flag set with protection off");
	a_join_hl: assert property (prim && hl && lts_ok && join_st_r == ST_SPLIT
		|-> ##[1:2] stores_joined_r)
		else $error("stores not joined on harvest-low");
	a_cutoff_split: assert property (prot_on && !lts_ok |=> !stores_joined_r)
		else $error("stores joined below cutoff");
	a_conv_off: assert property (power_switch_enable_r[7] |=> step_up_converter_off_r)
		else $error("converter not forced off");
	a_key_gate: assert property (boot_done && reg_wr_en && reg_wr_addr == ADDR_STORE_CELL
		&& protect_key_r != KEY_UNLOCK |=> $stable(store_cell_config_r))
		else $error("protected write without key");
	a_lux_gate: assert property (prim && !store_cell_config_r[2] |=> !lux_allowed_r)
		else $error("lux allowed without forced join");

	c_auto_join: cover property (join_st_r == ST_CONFIRM ##1 join_st_r == ST_JOINED);
	c_force_join: cover property (force_join ##1 stores_joined_r);
	c_aux_gnd: cover property (aux_out_r[2] == OUT_GND);
	c_main_reg: cover property (main_out_r == OUT_REG);

endmodule // ssc_supply_ctrl

//--- testbench.sv
// self-checking bench for the supply switch and cell control block
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module testbench
	import ssc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CC = 10;
	logic        clk = 0, rst_n = 0, boot_done = 0, nvm_en = 0, wr_en = 0;
	logic        txn_end = 0, hl = 0, sts_tick = 0, hrv_tick = 0;
	logic [7:0]  nvm_addr = 0, nvm_data = 0, wr_addr = 0, wr_data = 0, rd_addr = 0;
	logic [5:0]  thr_code = 0;
	logic [15:0] sts_mv = 16'd2500, lts_mv = 16'd3000;
	logic        lo, ap, bs, lok, reg_on, conv_off, charge, joined, guard, lux;
	logic [7:0]  rd_data;
	logic [2:0]  gnd;
	logic [11:0] main_mv, aux_mv;
	logic [6:0]  thr_units;
	ssc_out_type main_out;
	ssc_out_type aux_out [3];
	int          m [256];
	int          ad [6] = '{6, 14, 15, 16, 17, 25};
	int          mv_tab [8] = '{1200, 1550, 1650, 1800, 2000, 2200, 2400, 2600};
	int          n_mismatch = 0;
	int          compares = 0;

	ssc_env_model u_ssc_env_model (.clk(clk), .sts_mv(sts_mv), .lts_mv(lts_mv),
		.above_low(lo), .above_app(ap), .below_split(bs), .lts_ok(lok));
	ssc_supply_ctrl #(.CONFIRM_CYC(CC)) u_ssc_supply_ctrl (.clk(clk), .rst_n(rst_n),
		.boot_done(boot_done), .nvm_load_en(nvm_en), .nvm_load_addr(nvm_addr),
		.nvm_load_data(nvm_data), .reg_wr_en(wr_en), .reg_wr_addr(wr_addr),
		.reg_wr_data(wr_data), .reg_rd_addr(rd_addr), .txn_end(txn_end),
		.sts_above_store_low_upper(lo), .sts_above_app_high(ap),
		.sts_below_split_low_upper(bs), .lts_above_store_cutoff(lok), .harvest_low(hl),
		.sts_meas_tick(sts_tick), .hrv_meas_tick(hrv_tick), .thr_code(thr_code),
		.reg_rd_data_r(rd_data), .main_out_r(main_out), .aux_out_r(aux_out),
		.aux_gnd_connect_r(gnd), .main_reg_on_r(reg_on), .main_level_mv_r(main_mv),
		.aux_level_mv_r(aux_mv), .step_up_converter_off_r(conv_off),
		.lts_charge_allowed_r(charge), .stores_joined_r(joined),
		.battery_guard_active_r(guard), .lux_allowed_r(lux), .thr_units_r(thr_units));

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// writable bits of each register; unmapped places read 0
	function automatic int msk(int a);
		case (a)
			6, 17: return 8'h07;
			14, 27: return 8'hff;
			15: return 8'h7f;
			16: return 8'h3f;
			25: return 8'hfe;
			default: return 0;
		endcase
	endfunction

	task automatic wr(int a, int d, bit key);
		if (key)
			wr(27, 8'h4b, 0);
		wr_en = 1;
		wr_addr = a[7:0];
		wr_data = d[7:0];
		step(1);
		wr_en = 0;
		step(1);
		if (key || a > 24)
			m[a] = d & msk(a);
	endtask

	task automatic txn();
		txn_end = 1;
		step(1);
		txn_end = 0;
		m[27] = 0;
		step(1);
	endtask

	task automatic pw(int a, int d);
		wr(a, d, 1);
		txn();
	endtask

	task automatic rd(int a);
		rd_addr = a[7:0];
		step(1);
		`CHK("read data", m[a][7:0], rd_data)
	endtask

	task automatic tick(bit hrv);
		if (hrv)
			hrv_tick = 1;
		else
			sts_tick = 1;
		step(1);
		hrv_tick = 0;
		sts_tick = 0;
		step(2);
	endtask

	task automatic jchk(int j, int l);
		step(5);
		`CHK("joined", j, joined)
		`CHK("lux allowed", l, lux)
	endtask

	task automatic chk_out();
		int s, e, on;
		step(5);
		on = lo && !(hl && m[15][0]);
		e = !on ? (m[14][7] ? 3 : 0) : (ap || m[14][3]) ? 2 : 1;
		`CHK("main out", e, main_out)
		`CHK("main regulator", on && (ap || m[14][3]), reg_on)
		for (int i = 0; i < 3; i++)
		begin
			s = (m[16] >> (2 * i)) & 3;
			on = m[25][i + 1] && lo && !(hl && m[15][i + 1]);
			e = !on ? (s == 3 ? 3 : 0) : s == 0 ? 1 : s == 1 ? 2 : ap ? 2 : 1;
			`CHK("aux out", e, aux_out[i])
			e = m[25][i + 4] && lo && !(m[17][i] && ap) && !(hl && m[15][i + 4]);
			`CHK("ground", e, gnd[i])
		end
		`CHK("main level", mv_tab[m[14] & 7], main_mv)
		`CHK("aux level", mv_tab[(m[14] >> 4) & 7], aux_mv)
		`CHK("converter off", m[25][7], conv_off)
		`CHK("charge allowed", !m[6][1], charge)
	endtask

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		end_of_test();
	end

	initial
	begin
		int d;
		void'($urandom(32'hc0d8ef1e));
		step(8);
		rst_n = 1;
		foreach (ad[k])
			rd(ad[k]);
		foreach (ad[k])
		begin
			d = $urandom & (ad[k] == 6 ? 8'hf9 : 8'hff);
			nvm_en = 1;
			nvm_addr = ad[k][7:0];
			nvm_data = d[7:0];
			step(1);
			nvm_en = 0;
			step(1);
			m[ad[k]] = d & msk(ad[k]);
		end
		step(5);
		`CHK("boot main", OUT_FLOAT, main_out)
		`CHK("boot aux", OUT_FLOAT, aux_out[0] | aux_out[1] | aux_out[2])
		`CHK("boot ground", 3'h0, gnd)
		boot_done = 1;
		foreach (ad[k])
			rd(ad[k]);
		chk_out();
		$display("done: boot");

		foreach (ad[k])
		begin
			pw(ad[k], $urandom & (ad[k] == 6 ? 8'hf9 : 8'hff));
			rd(ad[k]);
		end
		wr(14, 8'h5a, 0);
		rd(14);
		wr(27, 8'h4b, 0);
		txn();
		wr(14, 8'h33, 0);
		rd(14);
		rd(27);
		pw(18, 8'hff);
		rd(18);
		$display("done: registers");

		for (int k = 0; k < 12; k++)
		begin
			pw(14, $urandom);
			pw(15, $urandom);
			pw(16, k < 4 ? k * 21 : $urandom);
			pw(17, $urandom);
			wr(25, $urandom, 0);
			for (int v = 0; v < 6; v++)
			begin
				hl = v[0];
				sts_mv = v < 2 ? 16'd1000 : v < 4 ? 16'd2500 : 16'd4000;
				chk_out();
			end
		end
		hl = 0;
		for (int c = 0; c < 8; c++)
		begin
			pw(14, c * 17);
			chk_out();
		end
		$display("done: outputs");

		sts_mv = 16'd2500;
		wr(25, 8'h00, 0);
		pw(6, 8'h02);
		jchk(0, 0);
		`CHK("charge in primary", 1'b0, charge)
		pw(6, 8'h06);
		jchk(1, 1);
		`CHK("harvest stopped", 1'b1, conv_off)
		lts_mv = 16'd1000;
		jchk(0, 0);
		`CHK("guard flag", 1'b1, guard)
		pw(6, 8'h07);
		jchk(1, 1);
		`CHK("guard off", 1'b0, guard)
		lts_mv = 16'd3000;
		pw(6, 8'h02);
		jchk(0, 0);
		hl = 1;
		jchk(1, 0);
		hl = 0;
		jchk(1, 0);
		tick(1);
		jchk(1, 0);
		tick(1);
		jchk(0, 0);
		sts_mv = 16'd2200;
		step(4);
		tick(0);
		jchk(0, 0);
		step(12);
		jchk(1, 0);
		sts_mv = 16'd2500;
		tick(1);
		tick(1);
		jchk(0, 0);
		sts_mv = 16'd2200;
		step(4);
		tick(0);
		sts_mv = 16'd2500;
		step(16);
		jchk(0, 0);
		$display("done: store joining");

		for (int k = 0; k < 6; k++)
		begin
			thr_code = 6'($urandom);
			step(3);
			`CHK("threshold units", {1'b0, thr_code} + 7'd1, thr_units)
		end
		$display("done: thresholds");
		end_of_test();
	end
endmodule // testbench
